// file: include/pepfm_pkg.sv
// Package for the port E pin function multiplexer
package pepfm_pkg;

   // Register byte offsets
   localparam logic [3:0] OFS_PIN_VALUE    = 4'h0;
   localparam logic [3:0] OFS_OUT_LATCH    = 4'h4;
   localparam logic [3:0] OFS_DIRECTION    = 4'h8;
   localparam logic [3:0] OFS_PORTA_LATCH  = 4'hC;

   // Reset values
   localparam logic [7:0] RST_OUT_LATCH    = 8'h00;
   localparam logic [7:0] RST_DIRECTION    = 8'hFF;
   localparam logic [7:0] RST_PORTA_LATCH  = 8'h00;

   // Pull-up enable positions in the port A latch
   localparam int         BIT_PORT_E_PIN_VALUE_PU     = 6;
   localparam int         BIT_PORTD_PU     = 7;

   // Special pins
   localparam int         PIN_CCP2         = 7;
   localparam int         PIN_PSP_RD       = 0;
   localparam int         PIN_PSP_WR       = 1;
   localparam int         PIN_PSP_CS       = 2;

   // Implemented-bit masks per package variant
   localparam logic [7:0] MASK_SMALL       = 8'h3F;
   localparam logic [7:0] MASK_FULL        = 8'hFF;

   // Package variant
   typedef enum logic [1:0]
   {
      PEPFM_PKG_SMALL = 2'b00,
      PEPFM_PKG_MID   = 2'b01,
      PEPFM_PKG_LARGE = 2'b10
   } pepfm_variant_t;

   // AXI responses
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage

// file: hdl/pepfm_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/100ps
module pepfm_sync
#(
   parameter int W = 8
)
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pepfm_sync_t;

   pepfm_sync_t st_r;
   pepfm_sync_t st_nxt;

   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.s2;

endmodule // pepfm_sync

// file: hdl/pepfm_port.sv
// Port E register block and pin function multiplexer with AXI4-Lite slave
//
// Behaviour
// [R01] An output-direction pin with no owning peripheral drives its output latch bit.
// [R02] An input-direction pin is captured as port data, with a weak pull-up when enabled.
// [R03] External memory bus use of a pin overrides every other function and the direction bit.
// [R04] In memory bus mode each pin drives and accepts address/data bits 8 to 15.
// [R05] Memory bus pin functions exist only in the largest package variant.
// [R06] Active PWM channel outputs on output pins win over latch and parallel port data.
// [R07] PWM channel pins float during a shutdown event when so configured.
// [R08] Pin 7 in module-2 compare/PWM use drives compare/PWM when output, else feeds capture.
// [R09] Mid and large variants map PWM1 and PWM3 channels B/C here when pin-map bit set.
// [R10] Mid and large variants map module-2 channel A to pin 7 in MCU mode with its bit clear.
// [R11] The smallest variant has port bits 7 and 6 unimplemented, reading zero.
// [R12] Parallel slave port control functions exist only in the largest variant.
// [R13] Port A latch bit 6 enables port E pull-ups and bit 7 enables port D pull-ups.
// [R14] Parallel slave port mode turns pins 0 to 2 into read, write and select inputs.
`timescale 1ns/100ps
module pepfm_port
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Static device configuration
   input  wire logic [1:0]  pkg_variant,
   input  wire logic        mcu_mode,
   input  wire logic        pwm_pin_map_select,
   input  wire logic        module2_pin_map_select,
   // Peripheral side
   input  wire logic        external_memory_bus,
   input  wire logic [7:0]  ext_bus_addr_data_out,
   input  wire logic        ext_bus_drive,
   output logic [7:0]       ext_bus_data_in,
   input  wire logic        pwm1_channel_b,
   input  wire logic        pwm1_channel_c,
   input  wire logic        pwm3_channel_b,
   input  wire logic        pwm3_channel_c,
   input  wire logic        pwm2_channel_a,
   input  wire logic        pwm_active,
   input  wire logic        pwm_shutdown_float,
   input  wire logic        compare_capture_pwm_module2,
   output logic             module2_capture_in,
   input  wire logic        parallel_slave_port_mode,
   output logic             psp_read_n,
   output logic             psp_write_n,
   output logic             psp_select_n,
   output logic             port_d_pullup_enable,
   // Pins
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe,
   output logic [7:0]       pin_pullup
);

   ////////////////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [7:0]  latch;
      logic [7:0]  dir;
      logic [7:0]  porta;
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic        w_got;
      logic [3:0]  aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [7:0]  pout;
      logic [7:0]  poe;
      logic [7:0]  ppu;
      logic [7:0]  ebin;
      logic        cap;
      logic [2:0]  parallel_slave_port;
      logic        dpu;
   } pepfm_state_t;

   pepfm_state_t st_r;
   pepfm_state_t st_nxt;

   logic [7:0] pin_sync;

   pepfm_sync #(.W(8)) i_pepfm_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (pin_in),
      .q       (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Variant decode
   logic       is_large;
   logic       is_mid_up;
   logic [7:0] impl_mask;
   logic       emb_on;
   logic       psp_on;
   logic       map_bc;
   logic       map_p2a;
   logic       psp_live;
   logic [7:0] pin_view;

   always_comb
   begin
      is_large  = (pkg_variant == pepfm_pkg::PEPFM_PKG_LARGE);
      is_mid_up = is_large || (pkg_variant == pepfm_pkg::PEPFM_PKG_MID);
      impl_mask = (pkg_variant == pepfm_pkg::PEPFM_PKG_SMALL) ?
                  pepfm_pkg::MASK_SMALL : pepfm_pkg::MASK_FULL; // R11
      emb_on    = is_large && external_memory_bus; // R05
      psp_on    = is_large && parallel_slave_port_mode; // R12
      map_bc    = is_mid_up && pwm_pin_map_select; // R09
      map_p2a   = is_mid_up && mcu_mode && !module2_pin_map_select; // R10
      // Memory bus wins over the parallel port controls
      psp_live  = psp_on && !emb_on; // R03 R14
      pin_view  = pin_sync & impl_mask; // R11
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Pin multiplexer
   logic [7:0] pwm_own;
   logic [7:0] pwm_val;
   logic       ccp_own;
   logic [7:0] drv_out;
   logic [7:0] drv_oe;
   logic       pe_pu;

   always_comb
   begin
      pwm_own = 8'h00;
      pwm_val = 8'h00;
      pwm_own[3] = map_bc && pwm_active;
      pwm_val[3] = pwm3_channel_c;
      pwm_own[4] = map_bc && pwm_active;
      pwm_val[4] = pwm3_channel_b;
      pwm_own[5] = map_bc && pwm_active;
      pwm_val[5] = pwm1_channel_c;
      pwm_own[6] = map_bc && pwm_active;
      pwm_val[6] = pwm1_channel_b;
      pwm_own[7] = map_p2a && pwm_active;
      pwm_val[7] = pwm2_channel_a;
      // Small variant lacks pins 7 and 6, so nothing may own them
      pwm_own    = pwm_own & impl_mask;
      ccp_own    = map_p2a && compare_capture_pwm_module2 && !pwm_own[pepfm_pkg::PIN_CCP2]
                   && impl_mask[pepfm_pkg::PIN_CCP2];
      pe_pu      = st_r.porta[pepfm_pkg::BIT_PORT_E_PIN_VALUE_PU]; // R13
      drv_out    = 8'h00;
      drv_oe     = 8'h00;
      // Priority: memory bus, PWM channel, module-2 compare, latch
      for (int i = 0; i < 8; i++)
      begin
         if (emb_on)
         begin
            drv_out[i] = ext_bus_addr_data_out[i]; // R03 R04
            drv_oe[i]  = ext_bus_drive; // R03
         end
         else if (!st_r.dir[i] && pwm_own[i])
         begin
            drv_out[i] = pwm_val[i]; // R06
            drv_oe[i]  = !pwm_shutdown_float; // R07
         end
         else if (!st_r.dir[i] && ccp_own && (i == pepfm_pkg::PIN_CCP2))
         begin
            drv_out[i] = pwm2_channel_a; // R08
            drv_oe[i]  = 1'b1; // R08
         end
         else if (!st_r.dir[i])
         begin
            drv_out[i] = st_r.latch[i]; // R01
            drv_oe[i]  = 1'b1; // R01
         end
      end
      drv_out = drv_out & impl_mask; // R11
      drv_oe  = drv_oe & impl_mask;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register bus and registered outputs
   logic [7:0]  wr_byte;
   logic [7:0]  rd_byte;
   logic        rd_hit;
   logic        wr_hit;

   always_comb
   begin
      st_nxt  = st_r;
      wr_byte = st_r.w_data[7:0];
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      wr_hit  = 1'b1;

      // Address and data taken in either order
      if (s_axi_awvalid && st_r.awready)
      begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
         st_nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && st_r.wready)
      begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
         st_nxt.wready = 1'b0;
      end
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
      begin
         // Only byte lane 0 has storage; other lanes are ignored
         case (st_r.aw_addr)
            pepfm_pkg::OFS_PIN_VALUE,
            pepfm_pkg::OFS_OUT_LATCH:
            begin
               if (st_r.w_strb[0])
                  st_nxt.latch = wr_byte & impl_mask; // R11
            end
            pepfm_pkg::OFS_DIRECTION:
            begin
               if (st_r.w_strb[0])
                  st_nxt.dir = wr_byte & impl_mask; // R11
            end
            pepfm_pkg::OFS_PORTA_LATCH:
            begin
               if (st_r.w_strb[0])
                  st_nxt.porta = wr_byte;
            end
            default:
            begin
               wr_hit = 1'b0;
            end
         endcase
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = wr_hit ? pepfm_pkg::RESP_OKAY : pepfm_pkg::RESP_SLVERR;
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid  = 1'b0;
         st_nxt.awready = 1'b1;
         st_nxt.wready  = 1'b1;
      end

      // Reads answer one cycle after the address is taken
      // Unimplemented bits read zero even if stored under another variant
      case (s_axi_araddr)
         pepfm_pkg::OFS_PIN_VALUE:   rd_byte = pin_view; // R02
         pepfm_pkg::OFS_OUT_LATCH:   rd_byte = st_r.latch & impl_mask; // R11
         pepfm_pkg::OFS_DIRECTION:   rd_byte = st_r.dir & impl_mask; // R11
         pepfm_pkg::OFS_PORTA_LATCH: rd_byte = st_r.porta;
         default:
         begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
      if (s_axi_arvalid && st_r.arready)
      begin
         st_nxt.arready = 1'b0;
         st_nxt.rvalid  = 1'b1;
         st_nxt.rdata   = {24'h000000, rd_byte};
         st_nxt.rresp   = rd_hit ? pepfm_pkg::RESP_OKAY : pepfm_pkg::RESP_SLVERR;
      end
      if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid  = 1'b0;
         st_nxt.arready = 1'b1;
      end

      // Pin side, one register stage so every output is a flip-flop
      st_nxt.pout = drv_out;
      st_nxt.poe  = drv_oe;
      // Pull-ups never fight the memory bus drivers
      st_nxt.ppu  = (pe_pu && !emb_on) ? (st_r.dir & impl_mask) : 8'h00; // R02 R13
      st_nxt.ebin = emb_on ? pin_sync : 8'h00; // R04
      st_nxt.cap  = ccp_own && !emb_on && st_r.dir[pepfm_pkg::PIN_CCP2]
                    && pin_view[pepfm_pkg::PIN_CCP2]; // R03 R08
      // Inactive controls idle high; direction bits still must be input
      st_nxt.parallel_slave_port[0] = !(psp_live && st_r.dir[pepfm_pkg::PIN_PSP_RD]) ||
                      pin_sync[pepfm_pkg::PIN_PSP_RD]; // R14
      st_nxt.parallel_slave_port[1] = !(psp_live && st_r.dir[pepfm_pkg::PIN_PSP_WR]) ||
                      pin_sync[pepfm_pkg::PIN_PSP_WR]; // R14
      st_nxt.parallel_slave_port[2] = !(psp_live && st_r.dir[pepfm_pkg::PIN_PSP_CS]) ||
                      pin_sync[pepfm_pkg::PIN_PSP_CS]; // R14
      st_nxt.dpu  = st_r.porta[pepfm_pkg::BIT_PORTD_PU]; // R13
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r         <= '0;
         st_r.latch   <= pepfm_pkg::RST_OUT_LATCH;
         st_r.dir     <= pepfm_pkg::RST_DIRECTION;
         st_r.porta   <= pepfm_pkg::RST_PORTA_LATCH;
         // Readies idle high so the first request is taken at once
         st_r.awready <= 1'b1;
         st_r.wready  <= 1'b1;
         st_r.arready <= 1'b1;
         st_r.parallel_slave_port     <= 3'h7;
      end
      else
         st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready        = st_r.awready;
   assign s_axi_wready         = st_r.wready;
   assign s_axi_bresp          = st_r.bresp;
   assign s_axi_bvalid         = st_r.bvalid;
   assign s_axi_arready        = st_r.arready;
   assign s_axi_rdata          = st_r.rdata;
   assign s_axi_rresp          = st_r.rresp;
   assign s_axi_rvalid         = st_r.rvalid;
   assign ext_bus_data_in      = st_r.ebin;
   assign module2_capture_in   = st_r.cap;
   assign psp_read_n           = st_r.parallel_slave_port[0];
   assign psp_write_n          = st_r.parallel_slave_port[1];
   assign psp_select_n         = st_r.parallel_slave_port[2];
   assign port_d_pullup_enable = st_r.dpu;
   assign pin_out              = st_r.pout;
   assign pin_oe               = st_r.poe;
   assign pin_pullup           = st_r.ppu;

endmodule // pepfm_port

// file: verification/pepfm_port_sva.sv
// Pin-side assertions for the port E multiplexer
`timescale 1ns/100ps
module pepfm_port_sva
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [1:0] pkg_variant,
   input wire logic       mcu_mode,
   input wire logic       pwm_pin_map_select,
   input wire logic       module2_pin_map_select,
   input wire logic       external_memory_bus,
   input wire logic [7:0] ext_bus_addr_data_out,
   input wire logic       ext_bus_drive,
   input wire logic [7:0] ext_bus_data_in,
   input wire logic       pwm1_channel_b,
   input wire logic       pwm1_channel_c,
   input wire logic       pwm3_channel_b,
   input wire logic       pwm3_channel_c,
   input wire logic       pwm2_channel_a,
   input wire logic       pwm_active,
   input wire logic       pwm_shutdown_float,
   input wire logic       compare_capture_pwm_module2,
   input wire logic       parallel_slave_port_mode,
   input wire logic       psp_read_n,
   input wire logic       psp_write_n,
   input wire logic       psp_select_n,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pin_pullup
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   wire emb_on  = pkg_variant == 2'h2 && external_memory_bus;
   wire pwm_own = pkg_variant != 2'h0 && pwm_pin_map_select && pwm_active && !external_memory_bus;
   wire m2_own  = pkg_variant != 2'h0 && mcu_mode && !module2_pin_map_select
                  && compare_capture_pwm_module2 && !external_memory_bus;
   ////////////////////////////////////////////////////////////////////////////////
   chk_emb_drive: assert property (emb_on && ext_bus_drive
      |=> pin_oe == 8'hFF && pin_out == $past(ext_bus_addr_data_out)) else $error("bus drive");
   chk_emb_override: assert property (emb_on |=> pin_pullup == 8'h00
      && {psp_read_n, psp_write_n, psp_select_n} == 3'b111) else $error("bus override");
   chk_emb_absent: assert property (pkg_variant != 2'h2 |=> ext_bus_data_in == 8'h00)
      else $error("bus input present");
   chk_pwm_priority: assert property (pwm_own && !pwm_shutdown_float ##1 pin_oe[6:3] == 4'hF
      |-> pin_out[6:3] == $past({pwm1_channel_b, pwm1_channel_c, pwm3_channel_b, pwm3_channel_c}))
      else $error("pwm priority");
   chk_pwm_float: assert property (pwm_own && pwm_shutdown_float |=> pin_oe[6:3] == 4'h0)
      else $error("pwm float");
   chk_ccp2_out: assert property (m2_own ##1 pin_oe[7] |-> pin_out[7] == $past(pwm2_channel_a))
      else $error("compare output");
   chk_small_pins: assert property (pkg_variant == 2'h0
      |=> pin_oe[7:6] == 2'h0 && pin_pullup[7:6] == 2'h0) else $error("small variant pins");
   chk_psp_absent: assert property (pkg_variant != 2'h2 || !parallel_slave_port_mode
      |=> {psp_read_n, psp_write_n, psp_select_n} == 3'b111) else $error("psp inputs");
   cover property (emb_on && ext_bus_drive);
   cover property (pwm_own && pwm_shutdown_float);
   cover property (!psp_select_n);
endmodule // pepfm_port_sva

bind pepfm_port pepfm_port_sva i_pepfm_port_sva (.*);

// file: verification/pepfm_board.sv
// Board model on the port E pins
`timescale 1ns/100ps
module pepfm_board
(
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pullup,
   input  wire logic [7:0] board_level,
   output logic      [7:0] pin_in
);
   // Driven pin wins; undriven pin with pull-up reads high
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | board_level));
endmodule // pepfm_board

// file: verification/test_port_e_pin_function_mux.sv
// Testbench for the port E pin function multiplexer
`timescale 1ns/100ps
module test_port_e_pin_function_mux;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, mcu_mode, pwm_pin_map_select, module2_pin_map_select;
   logic        external_memory_bus, ext_bus_drive, pwm1_channel_b, pwm1_channel_c;
   logic        pwm3_channel_b, pwm3_channel_c, pwm2_channel_a, pwm_active, pwm_shutdown_float;
   logic        compare_capture_pwm_module2, module2_capture_in, parallel_slave_port_mode;
   logic        psp_read_n, psp_write_n, psp_select_n, port_d_pullup_enable;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pkg_variant, resp;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [7:0]  ext_bus_addr_data_out, ext_bus_data_in, pin_in, pin_out, pin_oe, pin_pullup;
   logic [7:0]  board, v, d;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   int          err_total, tests_run;

   pepfm_port  i_pepfm_port (.*);
   pepfm_board i_pepfm_board (.*, .board_level(board));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] impl(input logic [1:0] vsel, input logic [7:0] x);
      return (vsel == 2'h0) ? (x & 8'h3F) : x;
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] x);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, x};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      // bready stays high after the call; every call drives it high again along with both valids
      resp = s_axi_bresp;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] x);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      x = s_axi_rdata[7:0];
      resp = s_axi_rresp;
   endtask

   // Pin outputs are registered; look at them mid-cycle
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic results;
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Whole run is a few hundred cycles; this is far beyond it
   initial
   begin
      #2000000;
      err_total++;
      results();
   end

   initial
   begin
      err_total = 0;
      tests_run = 0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {mcu_mode, pwm_pin_map_select, module2_pin_map_select, external_memory_bus} = '0;
      {ext_bus_drive, pwm1_channel_b, pwm1_channel_c, pwm3_channel_b, pwm3_channel_c} = '0;
      {pwm2_channel_a, pwm_active, pwm_shutdown_float, compare_capture_pwm_module2} = '0;
      {parallel_slave_port_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {ext_bus_addr_data_out, board} = '0;
      s_axi_wstrb = 4'hF;
      pkg_variant = 2'h2;
      v = $urandom(46);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(4'h4, d);
      chk("latch reset", 8'h00, d);
      rd(4'h8, d);
      chk("direction reset", 8'hFF, d);
      rd(4'hC, d);
      chk("porta reset", 8'h00, d);
      rd(4'h2, d);
      chk("unmapped resp", 8'h02, {6'h00, resp});
      wr(4'h2, 8'h00);
      chk("unmapped wresp", 8'h02, {6'h00, resp});
      $display("test reset done");
      wr(4'h8, 8'h00);
      chk("write resp", 8'h00, {6'h00, resp});
      repeat (4)
      begin
         v = $urandom();
         board <= $urandom();
         wr(4'h4, v);
         wt(1);
         chk("pin_out", v, pin_out);
         chk("pin_oe", 8'hFF, pin_oe);
         @(posedge aclk);
      end
      $display("test output done");
      v = $urandom();
      board <= v;
      wr(4'h8, 8'hFF);
      wt(4);
      @(posedge aclk);
      rd(4'h0, d);
      chk("pin read", v, d);
      wr(4'hC, 8'h40);
      wt(3);
      chk("pullup", 8'hFF, pin_pullup);
      chk("pd pullup", 8'h00, {7'h00, port_d_pullup_enable});
      @(posedge aclk);
      rd(4'h0, d);
      chk("pulled read", 8'hFF, d);
      wr(4'hC, 8'h80);
      wt(1);
      chk("pullup off", 8'h00, pin_pullup);
      chk("pd pullup", 8'h01, {7'h00, port_d_pullup_enable});
      @(posedge aclk);
      $display("test input done");
      pkg_variant <= 2'h0;
      wr(4'h0, 8'hFF);
      rd(4'h4, d);
      chk("small latch", impl(2'h0, 8'hFF), d);
      s_axi_wstrb <= 4'hE;
      wr(4'h4, 8'h00);
      rd(4'h4, d);
      chk("strobe off", impl(2'h0, 8'hFF), d);
      s_axi_wstrb <= 4'hF;
      rd(4'h8, d);
      chk("small dir", impl(2'h0, 8'hFF), d);
      pkg_variant <= 2'h2;
      $display("test small done");
      v = $urandom();
      {external_memory_bus, ext_bus_drive} <= 2'h3;
      ext_bus_addr_data_out <= v;
      wt(1);
      chk("bus out", v, pin_out);
      chk("bus oe", 8'hFF, pin_oe);
      @(posedge aclk);
      v = $urandom();
      ext_bus_drive <= 1'b0;
      board <= v;
      wt(5);
      chk("bus in", v, ext_bus_data_in);
      @(posedge aclk);
      pkg_variant <= 2'h1;
      wt(2);
      chk("bus absent", 8'h00, ext_bus_data_in);
      @(posedge aclk);
      {pkg_variant, external_memory_bus, parallel_slave_port_mode} <= 4'h9;
      $display("test bus done");
      for (int k = 0; k < 8; k++)
      begin
         board <= {5'($urandom()), 3'(k)};
         wt(5);
         chk("psp", 8'(k), {5'h00, psp_select_n, psp_write_n, psp_read_n});
         @(posedge aclk);
      end
      {pkg_variant, board} <= {2'h1, 8'h00};
      wt(4);
      chk("psp absent", 8'h07, {5'h00, psp_select_n, psp_write_n, psp_read_n});
      @(posedge aclk);
      {pkg_variant, parallel_slave_port_mode} <= 3'h4;
      $display("test psp done");
      wr(4'h8, 8'h00);
      {pwm_pin_map_select, pwm_active} <= 2'h3;
      repeat (4)
      begin
         v = $urandom();
         {pwm1_channel_b, pwm1_channel_c, pwm3_channel_b, pwm3_channel_c} <= v[3:0];
         wt(1);
         chk("pwm pins", {4'h0, v[3:0]}, {4'h0, pin_out[6:3]});
         @(posedge aclk);
      end
      pwm_shutdown_float <= 1'b1;
      wt(1);
      chk("pwm float", 8'h00, {4'h0, pin_oe[6:3]});
      @(posedge aclk);
      pwm_pin_map_select <= 1'b0;
      wt(1);
      chk("pwm unmapped", 8'h0F, {4'h0, pin_oe[6:3]});
      @(posedge aclk);
      {pwm_active, pwm_shutdown_float} <= 2'h0;
      $display("test pwm done");
      v = $urandom();
      wr(4'h4, 8'h00);
      {mcu_mode, compare_capture_pwm_module2, pwm2_channel_a} <= {2'h3, v[0]};
      wt(1);
      chk("compare out", {7'h00, v[0]}, {7'h00, pin_out[7]});
      @(posedge aclk);
      {module2_pin_map_select, pwm2_channel_a} <= 2'h3;
      wt(1);
      chk("compare unmapped", 8'h00, {7'h00, pin_out[7]});
      @(posedge aclk);
      module2_pin_map_select <= 1'b0;
      wr(4'h8, 8'h80);
      board <= {v[1], 7'h00};
      wt(5);
      chk("capture", {7'h00, v[1]}, {7'h00, module2_capture_in});
      $display("test compare done");
      results();
   end
endmodule // test_port_e_pin_function_mux
